/* lcdc_ctrl.sv */
// LCD duty, common mux, operating clock and power control with APB slave
// Assumes the subClk tick is an asynchronous level input, synchronised here; the system clock is core_clk
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
`include "lcdc_params.svh"
module lcdc_ctrl (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`LCDC_ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Clock sources (subclock level from pin)
  input wire logic subClkIn,
  // Panel-side controls
  output logic [3:0] commonEnable,
  output logic [3:0] commonPhaseSel0,
  output logic [3:0] commonPhaseSel1,
  output lcdc_pkg::lcdc_duty_t dutyMode,
  output logic lcdClk,
  output logic drivePowerOn,
  output logic displayRun,
  output logic showRamData
);
  import lcdc_pkg::*;

  //////////////////////////////////////////////////////////////////////////////
  // Register storage and bus decode

  logic [7:0] ctrlQ;
  logic [7:0] modeQ;
  logic [7:0] ctrlD;
  logic [7:0] modeD;
  logic busAccess;
  logic hitCtrl;
  logic hitMode;

  // Byte address is four times the index
  function automatic logic hit(input logic [`LCDC_ADDR_W-1:0] a, input logic [`LCDC_ADDR_W-1:0] idx);
    hit = (a == {idx[`LCDC_ADDR_W-3:0], 2'b00});
  endfunction

  assign busAccess = psel && penable;
  assign hitCtrl = hit(paddr, `LCDC_CTRL_IDX);
  assign hitMode = hit(paddr, `LCDC_MODE_IDX);

  // Write data with top control bit forced high
  always_comb begin
    ctrlD = ctrlQ;
    modeD = modeQ;
    if (busAccess && pwrite && hitCtrl) begin
      ctrlD = pwdata[7:0];
    end
    if (busAccess && pwrite && hitMode) begin
      modeD = pwdata[7:0];
    end
    ctrlD[`LCDC_BIT_TOP] = 1'b1;
  end

  // Control register, resets with top bit one
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrlQ <= `LCDC_CTRL_RST;
    end else begin
      ctrlQ <= ctrlD;
    end
  end

  // Duty and common mux register
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      modeQ <= `LCDC_MODE_RST;
    end else begin
      modeQ <= modeD;
    end
  end

  // APB answer: no wait state, ready in the first access cycle, read data and error registered
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      pready <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
    end else begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !hit(paddr, `LCDC_CTRL_IDX) && !hit(paddr, `LCDC_MODE_IDX)
        && `LCDC_PSLVERR_UNMAPPED;
      if (psel && !penable && !pwrite) begin
        prdata <= hit(paddr, `LCDC_CTRL_IDX) ? {24'h0, ctrlQ} :
                  hit(paddr, `LCDC_MODE_IDX) ? {24'h0, modeQ} : 32'h0;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Duty decode and common multiplexing

  lcdc_duty_t dutyDec;
  logic commonMuxSel;
  logic [3:0] enD;
  logic [3:0] ph0D;
  logic [3:0] ph1D;

  assign commonMuxSel = modeQ[`LCDC_BIT_COMMON_MUX];

  // Duty code; 11 is treated as quarter duty
  always_comb begin
    case ({modeQ[`LCDC_BIT_DUTY_HI], modeQ[`LCDC_BIT_DUTY_LO]})
      2'h0: dutyDec = LCDC_STATIC;
      2'h1: dutyDec = LCDC_HALF;
      2'h2: dutyDec = LCDC_THIRD;
      default: dutyDec = LCDC_QUARTER;
    endcase
  end

  // Enable and phase per common; phase selects which time slot a common follows
  always_comb begin
    enD = 4'h0;
    ph0D = 4'h0;
    ph1D = 4'h0;
    case (dutyDec)
      LCDC_STATIC: begin
        enD = commonMuxSel ? 4'hF : 4'h1;
      end
      LCDC_HALF: begin
        enD = commonMuxSel ? 4'hF : 4'h3;
        ph0D = commonMuxSel ? 4'hC : 4'h2;
      end
      LCDC_THIRD: begin
        enD = 4'h7;
        ph0D = 4'h2;
        ph1D = 4'h4;
      end
      default: begin
        enD = 4'hF;
        ph0D = 4'hA;
        ph1D = 4'hC;
      end
    endcase
  end

  // Registered panel controls
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      commonEnable <= 4'h0;
      commonPhaseSel0 <= 4'h0;
      commonPhaseSel1 <= 4'h0;
      dutyMode <= LCDC_STATIC;
    end else begin
      commonEnable <= enD;
      commonPhaseSel0 <= ph0D;
      commonPhaseSel1 <= ph1D;
      dutyMode <= dutyDec;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Operating clock select

  logic subMeta;
  logic subSync;
  logic subPrev;
  logic subRise;
  logic [1:0] subDivQ;
  logic [`LCDC_DIV_W-1:0] sysDivQ;
  logic lcdClkD;
  logic [2:0] clkLow;

  // Two-flop synchroniser for the subclock pin
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      subMeta <= 1'b0;
      subSync <= 1'b0;
      subPrev <= 1'b0;
    end else begin
      subMeta <= subClkIn;
      subSync <= subMeta;
      subPrev <= subSync;
    end
  end

  assign subRise = subSync && !subPrev;

  // Subclock divider, counts subclock rising edges
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      subDivQ <= 2'h0;
    end else if (subRise) begin
      subDivQ <= subDivQ + 2'h1;
    end
  end

  // System clock divider
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      sysDivQ <= '0;
    end else begin
      sysDivQ <= sysDivQ + 9'h001;
    end
  end

  assign clkLow = ctrlQ[`LCDC_CLK_LOW_HI:0];

  // Clock mux: source bit picks system clock divided by 2 to the (low+1)
  always_comb begin
    if (ctrlQ[`LCDC_BIT_SRC] == LCDC_SRC_SYS) begin
      lcdClkD = sysDivQ[clkLow];
    end else if (clkLow[1]) begin
      lcdClkD = subDivQ[1];
    end else if (clkLow[0]) begin
      lcdClkD = subDivQ[0];
    end else begin
      lcdClkD = subSync;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Power, activation and display data

  // Output flops for clock and display state
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      lcdClk <= 1'b0;
      drivePowerOn <= 1'b0;
      displayRun <= 1'b0;
      showRamData <= 1'b0;
    end else begin
      lcdClk <= lcdClkD && ctrlQ[`LCDC_BIT_RUN];
      drivePowerOn <= ctrlQ[`LCDC_BIT_POWER];
      displayRun <= ctrlQ[`LCDC_BIT_RUN];
      showRamData <= ctrlQ[`LCDC_BIT_RUN] && ctrlQ[`LCDC_BIT_RAMDATA];
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Assertions

  // Bus handshake steps
  sequence s_ctrlWrite;
    psel && penable && pready && pwrite && hitCtrl;
  endsequence

  sequence s_setup;
    psel && !penable;
  endsequence

  // Bus answer: one access cycle, error on unmapped address
  a_ready_answer: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_setup |=> pready)
    else $error("no ready in access cycle");
  a_ready_single: assert property (@(posedge core_clk) disable iff (!rst_b)
    pready |=> !pready)
    else $error("ready held longer than one cycle");
  a_unmapped_err: assert property (@(posedge core_clk) disable iff (!rst_b)
    (psel && !penable && !hitCtrl && !hitMode) |=> pslverr)
    else $error("no error on unmapped address");

  // Control register contents
  a_power_follows: assert property (@(posedge core_clk) disable iff (!rst_b)
    s_ctrlWrite |=> ##1 (drivePowerOn == $past(pwdata[`LCDC_BIT_POWER], 2)))
    else $error("power output does not follow written bit");
  a_top_bit_one: assert property (@(posedge core_clk) disable iff (!rst_b)
    ctrlQ[`LCDC_BIT_TOP])
    else $error("control top bit not one");

  // Duty decode and common pairing
  a_static_mux: assert property (@(posedge core_clk) disable iff (!rst_b)
    (dutyDec == LCDC_STATIC && commonMuxSel) |=> (commonEnable == 4'hF && commonPhaseSel0 == 4'h0))
    else $error("static mux commons wrong");
  a_half_mux: assert property (@(posedge core_clk) disable iff (!rst_b)
    (dutyDec == LCDC_HALF && commonMuxSel) |=> (commonEnable == 4'hF && commonPhaseSel1 == 4'h0
      && commonPhaseSel0[3] == commonPhaseSel0[2] && commonPhaseSel0[1] == commonPhaseSel0[0]
      && commonPhaseSel0[2] != commonPhaseSel0[0]))
    else $error("half duty mux pairing wrong");
  a_half_plain: assert property (@(posedge core_clk) disable iff (!rst_b)
    (dutyDec == LCDC_HALF && !commonMuxSel) |=> (commonPhaseSel0 == 4'h2 && commonPhaseSel1 == 4'h0))
    else $error("half duty slots wrong");
  a_third_slots: assert property (@(posedge core_clk) disable iff (!rst_b)
    (dutyDec == LCDC_THIRD) |=> (commonEnable == 4'h7 && commonPhaseSel0 == 4'h2 && commonPhaseSel1 == 4'h4))
    else $error("third duty slots wrong");
  a_quarter_slots: assert property (@(posedge core_clk) disable iff (!rst_b)
    (dutyDec == LCDC_QUARTER) |=> (commonPhaseSel0 == 4'hA && commonPhaseSel1 == 4'hC))
    else $error("quarter duty slots wrong");
  a_duty_decode: assert property (@(posedge core_clk) disable iff (!rst_b)
    ({modeQ[`LCDC_BIT_DUTY_HI], modeQ[`LCDC_BIT_DUTY_LO]} == 2'h3)
    |=> (dutyMode == LCDC_QUARTER && commonEnable == 4'hF))
    else $error("quarter duty decode wrong");
  a_unused_off: assert property (@(posedge core_clk) disable iff (!rst_b)
    (!commonMuxSel && dutyDec == LCDC_HALF) |=> (commonEnable[3:2] == 2'h0))
    else $error("unused commons enabled");

  // Operating clock and halt
  a_halt_clock: assert property (@(posedge core_clk) disable iff (!rst_b)
    !ctrlQ[`LCDC_BIT_RUN] |=> (!lcdClk && !displayRun && !showRamData))
    else $error("clock or ram data active while halted");
  a_sys_div: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ctrlQ[`LCDC_BIT_RUN] && ctrlQ[`LCDC_BIT_SRC:0] == 4'h8) |=> (lcdClk == $past(sysDivQ[0])))
    else $error("system clock divide by two wrong");
  a_sub_quarter: assert property (@(posedge core_clk) disable iff (!rst_b)
    (ctrlQ[`LCDC_BIT_RUN] && ctrlQ[`LCDC_BIT_SRC] == LCDC_SRC_SUB && clkLow[1])
    |=> (lcdClk == $past(subDivQ[1])))
    else $error("subclock divide by four wrong");
endmodule

/* lcdc_panel.sv */
// LCD glass stand-in driven by the common and segment controls
// Assumes commonEnable marks the commons wired to the glass
`timescale 1ns/10ps
module lcdc_panel (
  // Controls from the driver
  input wire logic [3:0] commonEnable,
  input wire logic drivePowerOn,
  input wire logic showRamData,
  // Glass state
  output logic [2:0] usedCount,
  output logic glassLit
);
  // Only enabled commons are wired to the glass
  assign usedCount = 3'($countones(commonEnable));
  // Segments show only with supply on and RAM data picked
  assign glassLit = drivePowerOn & showRamData;
endmodule

/* lcdc_params.svh */
// Constants for the LCD duty and clock control block
// Assumes inclusion by the package and the design file
`ifndef LCDC_PARAMS_SVH
`define LCDC_PARAMS_SVH
`define LCDC_ADDR_W 12
`define LCDC_CTRL_IDX 12'h0C1
`define LCDC_MODE_IDX 12'h0C0
`define LCDC_CTRL_RST 8'h80
`define LCDC_MODE_RST 8'h00
`define LCDC_BIT_POWER 6
`define LCDC_BIT_RUN 5
`define LCDC_BIT_RAMDATA 4
`define LCDC_BIT_TOP 7
`define LCDC_BIT_SRC 3
`define LCDC_CLK_LOW_HI 2
`define LCDC_BIT_DUTY_HI 7
`define LCDC_BIT_DUTY_LO 6
`define LCDC_BIT_COMMON_MUX 5
`define LCDC_DIV_W 9
`define LCDC_PSLVERR_UNMAPPED 1'b1
`endif

/* lcdc_pkg.sv */
// Types for the LCD duty and clock control block
// Assumes the params header is on the include path
`include "lcdc_params.svh"
package lcdc_pkg;
  typedef enum logic [1:0] {
    LCDC_STATIC,
    LCDC_HALF,
    LCDC_THIRD,
    LCDC_QUARTER
  } lcdc_duty_t;
  typedef enum logic {
    LCDC_SRC_SUB,
    LCDC_SRC_SYS
  } lcdc_src_t;
endpackage

/* tb_top.sv */
// Testbench: APB access, duty decode, clock select and power controls
// Assumes lcdc_params.svh on the include path, panel model compiled first
`timescale 1ns/10ps
`include "lcdc_params.svh"
module tb_top;
  localparam logic [11:0] CTRL_A = `LCDC_CTRL_IDX << 2;
  localparam logic [11:0] MODE_A = `LCDC_MODE_IDX << 2;
  logic core_clk = 0, rst_b = 0, psel = 0, penable = 0, pwrite = 0, subClkIn = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, rd;
  logic pready, pslverr, er, lcdClk, drivePowerOn, displayRun, showRamData, glassLit;
  logic [3:0] commonEnable, commonPhaseSel0, commonPhaseSel1, en;
  logic [1:0] dutyMode;
  logic [2:0] usedCount;
  int errTotal = 0, totalChecks = 0, p, e, s;
  lcdc_ctrl u_lcdc_ctrl (.core_clk(core_clk), .rst_b(rst_b), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .subClkIn(subClkIn), .commonEnable(commonEnable),
    .commonPhaseSel0(commonPhaseSel0), .commonPhaseSel1(commonPhaseSel1), .dutyMode(dutyMode),
    .lcdClk(lcdClk), .drivePowerOn(drivePowerOn), .displayRun(displayRun), .showRamData(showRamData));
  lcdc_panel u_lcdc_panel (.commonEnable(commonEnable), .drivePowerOn(drivePowerOn),
    .showRamData(showRamData), .usedCount(usedCount), .glassLit(glassLit));
  ////////////////////////////////////////////////////////////////
  // Core clock and a subclock of 20 core cycles
  initial forever #5 core_clk = ~core_clk;
  initial forever begin
    repeat (10) @(posedge core_clk);
    subClkIn <= ~subClkIn;
  end
  ////////////////////////////////////////////////////////////////
  // Counts, verdict and compare
  task automatic giveVerdict;
    $display("checks %0d mismatches %0d", totalChecks, errTotal);
    if (errTotal == 0 && totalChecks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] x, input logic [31:0] g);
    totalChecks++;
    if (g !== x) begin
      $display("unexpected %s expected %h seen %h", nm, x, g);
      errTotal++;
    end
  endtask
  // One APB transfer, held until pready is sampled high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge core_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    while (pready !== 1'b1) begin
      n++;
      if (n > 20) begin
        errTotal++;
        giveVerdict();
      end
      @(posedge core_clk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Period of lcdClk between its second and third rise
  task automatic meas(output int q);
    int r[$];
    logic pv;
    pv = 1'b1;
    for (int n = 0; n < 1500 && r.size() < 3; n++) begin
      @(posedge core_clk);
      if (lcdClk === 1'b1 && pv !== 1'b1) r.push_back(n);
      pv = lcdClk;
    end
    if (r.size() < 3) begin
      errTotal++;
      giveVerdict();
    end
    q = r[2] - r[1];
  endtask
  // Model: enabled commons and time slot per mode {duty, mux}
  function automatic logic [3:0] expEn(input int m);
    case (m)
      0: return 4'h1;
      2: return 4'h3;
      4, 5: return 4'h7;
      default: return 4'hF;
    endcase
  endfunction
  function automatic int expSlot(input int m, input int i);
    if (m < 2) return 0;
    if (m == 3) return i >> 1;
    return i;
  endfunction
  ////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    void'($urandom(24688));
    repeat (5) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("commonEnable", 32'h1, commonEnable);
    chk("drivePowerOn", 32'h0, drivePowerOn);
    apb(0, CTRL_A, 0);
    chk("ctrl reset", 32'h80, rd);
    apb(0, MODE_A, 0);
    chk("mode reset", 32'h0, rd);
    $display("test reset done");
    for (int k = 0; k < 10; k++) begin
      logic [7:0] v;
      v = (k == 0) ? 8'hFF : (k == 1) ? 8'h00 : 8'($urandom);
      apb(1, CTRL_A, {24'h0, v});
      repeat (3) @(posedge core_clk);
      apb(0, CTRL_A, 0);
      chk("ctrl read", {24'h0, v | 8'h80}, rd);
      chk("drivePowerOn", v[6], drivePowerOn);
      chk("displayRun", v[5], displayRun);
      chk("showRamData", v[5] & v[4], showRamData);
      chk("glassLit", v[6] & v[5] & v[4], glassLit);
    end
    $display("test control bits done");
    for (int m = 0; m < 8; m++) begin
      apb(1, MODE_A, m << 5);
      repeat (3) @(posedge core_clk);
      en = expEn(m);
      chk("dutyMode", m >> 1, dutyMode);
      chk("commonEnable", en, commonEnable);
      chk("usedCount", $countones(en), usedCount);
      for (int i = 0; i < 4; i++) begin
        if (en[i]) begin
          s = expSlot(m, i);
          chk("slot lo", s & 1, commonPhaseSel0[i]);
          chk("slot hi", s >> 1, commonPhaseSel1[i]);
        end
      end
    end
    $display("test duty done");
    for (int c = 0; c < 16; c++) begin
      apb(1, CTRL_A, 32'h20 | c);
      meas(p);
      e = c[3] ? 2 << (c & 7) : c[1] ? 80 : c[0] ? 40 : 20;
      chk("lcdClk period", e, p);
    end
    apb(1, CTRL_A, 32'h0F);
    for (int n = 0; n < 6; n++) begin
      repeat (40) @(posedge core_clk);
      chk("lcdClk halted", 32'h0, lcdClk);
    end
    $display("test clock select done");
    apb(1, 12'h308, 32'hFF);
    chk("pslverr", 32'h1, er);
    apb(0, 12'h308, 0);
    chk("unmapped read", 32'h0, rd);
    chk("pslverr", 32'h1, er);
    apb(0, CTRL_A, 0);
    chk("ctrl kept", 32'h8F, rd);
    $display("test unmapped done");
    apb(1, CTRL_A, 32'h7F);
    rst_b <= 1'b0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk("drivePowerOn", 32'h0, drivePowerOn);
    chk("displayRun", 32'h0, displayRun);
    chk("commonEnable", 32'h1, commonEnable);
    apb(0, CTRL_A, 0);
    chk("ctrl reset", 32'h80, rd);
    $display("test second reset done");
    giveVerdict();
  end
endmodule
